//--- ctp_pkg.sv
// package for the cascadable timer pair: register map, fields, reset values
// What this block does
// - pair runs as one 32-bit timer or two independent 16-bit timers
// - arrangements: two 16-bit timers, one 32-bit timer, one 32-bit counter
// - each 16-bit timer counts internal or external clock, gated, prescaled
// - timers keep counting whatever the processor power state
// - cascaded pair flags a match of full 32-bit count against 32-bit period
// - converter trigger only from cascaded pair or its upper timer alone
// - lower timer holds low count word, upper timer the high word
// - when cascaded, upper control register bits are ignored
// - cascaded pair uses lower clock and gate, upper interrupt flag
// - two-bit prescale field divides the timer clock before counting
// - clock source bit and gate bit set clocking and gating modes
// - upper period gives high compare word, lower period the low word
// - live 32-bit count readable as upper and lower count registers
// - timer counts only while run bit 15 of its control is set; cascaded pair uses the lower run bit
package ctp_pkg;
    // register byte offsets
    localparam logic [7:0] CTP_LO_CTRL_OFS  = 8'h00;
    localparam logic [7:0] CTP_UP_CTRL_OFS  = 8'h04;
    localparam logic [7:0] CTP_LO_PER_OFS   = 8'h08;
    localparam logic [7:0] CTP_UP_PER_OFS   = 8'h0C;
    localparam logic [7:0] CTP_LO_CNT_OFS   = 8'h10;
    localparam logic [7:0] CTP_UP_CNT_OFS   = 8'h14;
    localparam logic [7:0] CTP_FLAG_OFS     = 8'h18;
    // control field positions
    localparam int CTP_RUN_BIT   = 15;
    localparam int CTP_GATE_BIT  = 6;
    localparam int CTP_PS_HI     = 5;
    localparam int CTP_PS_LO     = 4;
    localparam int CTP_CASC_BIT  = 3;
    localparam int CTP_CSRC_BIT  = 1;
    // flag register bit positions
    localparam int CTP_FLAG_LO   = 0;
    localparam int CTP_FLAG_UP   = 1;
    // reset values
    localparam logic [15:0] CTP_CTRL_RST = 16'h0000;
    localparam logic [15:0] CTP_PER_RST  = 16'hFFFF;
    localparam logic [15:0] CTP_CNT_RST  = 16'h0000;
    // prescale ratio encodings 1:1, 1:8, 1:64, 1:256 as terminal counts
    localparam logic [7:0] CTP_PS_TC0 = 8'h00;
    localparam logic [7:0] CTP_PS_TC1 = 8'h07;
    localparam logic [7:0] CTP_PS_TC2 = 8'h3F;
    localparam logic [7:0] CTP_PS_TC3 = 8'hFF;
    typedef enum logic [1:0] {CTP_HT_IDLE, CTP_HT_BUSY, CTP_HT_NSEQ, CTP_HT_SEQ} ctp_htrans_t;
endpackage : ctp_pkg

//--- ctp_timer_pair.sv
// cascadable 16/32-bit timer pair with ahb-lite register slave
`timescale 1ns/100ps
module ctp_timer_pair
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // external clock and gate pins, lower and upper
    input  wire logic        ext_clk_lo,
    input  wire logic        ext_clk_up,
    input  wire logic        gate_lo,
    input  wire logic        gate_up,
    // event outputs
    output logic             irq_lo,
    output logic             irq_up,
    output logic             adc_trigger
);
    import ctp_pkg::*;

    // bus and register state
    logic        wr_pend, next_wr_pend;
    logic [7:0]  wr_addr, next_wr_addr;
    logic [31:0] rdata, next_rdata;
    logic [15:0] ctrl_lo, next_ctrl_lo, ctrl_up, next_ctrl_up;
    logic [15:0] per_lo, next_per_lo, per_up, next_per_up;
    logic [15:0] cnt_lo, next_cnt_lo, cnt_up, next_cnt_up;
    logic [7:0]  ps_lo, next_ps_lo, ps_up, next_ps_up;
    logic        eclk_lo_q, next_eclk_lo_q, eclk_up_q, next_eclk_up_q;
    logic        gate_lo_q, next_gate_lo_q, gate_up_q, next_gate_up_q;
    logic        flag_lo, next_flag_lo, flag_up, next_flag_up;
    logic        trig, next_trig;

    // prescaler terminal count for a two-bit ratio field
    function automatic logic [7:0] ps_tc(input logic [1:0] sel);
        case (sel)
            2'h0:    ps_tc = CTP_PS_TC0;
            2'h1:    ps_tc = CTP_PS_TC1;
            2'h2:    ps_tc = CTP_PS_TC2;
            default: ps_tc = CTP_PS_TC3;
        endcase
    endfunction : ps_tc

    // raw count pulse: rising external edge, gated level, or every clock
    function automatic logic raw_tick(input logic [15:0] c, input logic ext_now,
                                      input logic ext_q, input logic gt_now,
                                      input logic gt_q);
        if (c[CTP_CSRC_BIT])
            raw_tick = ext_now & ~ext_q;
        else if (c[CTP_GATE_BIT])
            raw_tick = gt_now & gt_q;
        else
            raw_tick = 1'b1;
    endfunction : raw_tick

    logic cascade, run_lo, run_up, raw_lo, raw_up, tick_lo, tick_up;
    logic match_lo, match_up, match32, access;
    // counter and flag values from the timer logic, before any register write
    logic [15:0] hw_cnt_lo, hw_cnt_up;
    logic        hw_flag_lo, hw_flag_up;

    // mode decode and prescaled ticks; no idle/sleep input, so timers always run
    always_comb
    begin
        cascade  = ctrl_lo[CTP_CASC_BIT];
        run_lo   = ctrl_lo[CTP_RUN_BIT];
        run_up   = cascade ? 1'b0 : ctrl_up[CTP_RUN_BIT];
        raw_lo   = raw_tick(ctrl_lo, ext_clk_lo, eclk_lo_q, gate_lo, gate_lo_q);
        raw_up   = raw_tick(ctrl_up, ext_clk_up, eclk_up_q, gate_up, gate_up_q);
        // at or past terminal, so a ratio cut while running cannot stall the count
        tick_lo  = run_lo & raw_lo & (ps_lo >= ps_tc(ctrl_lo[CTP_PS_HI:CTP_PS_LO]));
        tick_up  = run_up & raw_up & (ps_up >= ps_tc(ctrl_up[CTP_PS_HI:CTP_PS_LO]));
        match_lo = cnt_lo == per_lo;
        match_up = cnt_up == per_up;
        match32  = match_lo & match_up;
        access   = hsel & hready & htrans[1];
    end

    // timer next state
    always_comb
    begin
        next_eclk_lo_q = ext_clk_lo;
        next_eclk_up_q = ext_clk_up;
        next_gate_lo_q = gate_lo;
        next_gate_up_q = gate_up;
        next_ps_lo = ps_lo;
        next_ps_up = ps_up;
        hw_cnt_lo = cnt_lo;
        hw_cnt_up = cnt_up;
        hw_flag_lo = flag_lo;
        hw_flag_up = flag_up;
        next_trig = 1'b0;
        // prescaler advances on raw ticks while running
        if (run_lo && raw_lo)
            next_ps_lo = tick_lo ? 8'h00 : ps_lo + 8'h01;
        if (run_up && raw_up)
            next_ps_up = tick_up ? 8'h00 : ps_up + 8'h01;
        // a stopped timer restarts its prescaler, so no stale phase carries over
        if (!run_lo)
            next_ps_lo = 8'h00;
        if (!run_up)
            next_ps_up = 8'h00;
        if (cascade)
        begin
            if (tick_lo)
            begin
                if (match32)
                begin
                    hw_cnt_lo = 16'h0000;
                    hw_cnt_up = 16'h0000;
                    hw_flag_up = 1'b1;
                    next_trig = 1'b1;
                end
                else
                begin
                    hw_cnt_lo = cnt_lo + 16'h0001;
                    if (cnt_lo == 16'hFFFF)
                        hw_cnt_up = cnt_up + 16'h0001;
                end
            end
        end
        else
        begin
            if (tick_lo)
            begin
                hw_cnt_lo = match_lo ? 16'h0000 : cnt_lo + 16'h0001;
                if (match_lo)
                    hw_flag_lo = 1'b1;
            end
            if (tick_up)
            begin
                hw_cnt_up = match_up ? 16'h0000 : cnt_up + 16'h0001;
                if (match_up)
                begin
                    hw_flag_up = 1'b1;
                    next_trig = 1'b1;
                end
            end
        end
    end

    // register file next state; writes land in the data phase
    always_comb
    begin
        next_wr_pend = access & hwrite;
        next_wr_addr = access ? haddr : wr_addr;
        next_rdata   = rdata;
        next_cnt_lo  = hw_cnt_lo;
        next_cnt_up  = hw_cnt_up;
        next_flag_lo = hw_flag_lo;
        next_flag_up = hw_flag_up;
        next_ctrl_lo = ctrl_lo;
        next_ctrl_up = ctrl_up;
        next_per_lo  = per_lo;
        next_per_up  = per_up;
        if (access && !hwrite)
        begin
            case (haddr)
                CTP_LO_CTRL_OFS: next_rdata = {16'h0000, ctrl_lo};
                CTP_UP_CTRL_OFS: next_rdata = {16'h0000, ctrl_up};
                CTP_LO_PER_OFS:  next_rdata = {16'h0000, per_lo};
                CTP_UP_PER_OFS:  next_rdata = {16'h0000, per_up};
                CTP_LO_CNT_OFS:  next_rdata = {16'h0000, cnt_lo};
                CTP_UP_CNT_OFS:  next_rdata = {16'h0000, cnt_up};
                CTP_FLAG_OFS:    next_rdata = {30'h0, flag_up, flag_lo};
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
        if (wr_pend)
        begin
            case (wr_addr)
                CTP_LO_CTRL_OFS: next_ctrl_lo = hwdata[15:0];
                CTP_UP_CTRL_OFS: next_ctrl_up = hwdata[15:0];
                CTP_LO_PER_OFS:  next_per_lo = hwdata[15:0];
                CTP_UP_PER_OFS:  next_per_up = hwdata[15:0];
                CTP_LO_CNT_OFS:  next_cnt_lo = hwdata[15:0];
                CTP_UP_CNT_OFS:  next_cnt_up = hwdata[15:0];
                // write one to clear; a same-cycle hardware set wins only if the flag was clear
                CTP_FLAG_OFS:
                begin
                    if (hwdata[CTP_FLAG_LO] && !(hw_flag_lo && !flag_lo))
                        next_flag_lo = 1'b0;
                    if (hwdata[CTP_FLAG_UP] && !(hw_flag_up && !flag_up))
                        next_flag_up = 1'b0;
                end
                default: ;
            endcase
        end
    end

    // all state registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            rdata     <= 32'h0000_0000;
            ctrl_lo   <= CTP_CTRL_RST;
            ctrl_up   <= CTP_CTRL_RST;
            per_lo    <= CTP_PER_RST;
            per_up    <= CTP_PER_RST;
            cnt_lo    <= CTP_CNT_RST;
            cnt_up    <= CTP_CNT_RST;
            ps_lo     <= 8'h00;
            ps_up     <= 8'h00;
            eclk_lo_q <= 1'b0;
            eclk_up_q <= 1'b0;
            gate_lo_q <= 1'b0;
            gate_up_q <= 1'b0;
            flag_lo   <= 1'b0;
            flag_up   <= 1'b0;
            trig      <= 1'b0;
        end
        else
        begin
            wr_pend   <= next_wr_pend;
            wr_addr   <= next_wr_addr;
            rdata     <= next_rdata;
            ctrl_lo   <= next_ctrl_lo;
            ctrl_up   <= next_ctrl_up;
            per_lo    <= next_per_lo;
            per_up    <= next_per_up;
            cnt_lo    <= next_cnt_lo;
            cnt_up    <= next_cnt_up;
            ps_lo     <= next_ps_lo;
            ps_up     <= next_ps_up;
            eclk_lo_q <= next_eclk_lo_q;
            eclk_up_q <= next_eclk_up_q;
            gate_lo_q <= next_gate_lo_q;
            gate_up_q <= next_gate_up_q;
            flag_lo   <= next_flag_lo;
            flag_up   <= next_flag_up;
            trig      <= next_trig;
        end
    end

    // outputs straight from flip-flops, hreadyout and hresp tied off; zero wait, always okay
    always_comb
    begin
        hrdata      = rdata;
        hreadyout   = 1'b1;
        hresp       = 1'b0;
        irq_lo      = flag_lo;
        irq_up      = flag_up;
        adc_trigger = trig;
    end

    // checks
    casc_wrap_a : assert property (@(posedge hclk) disable iff (!hresetn)
        cascade && tick_lo && cnt_lo == 16'hFFFF && !match32 |=> cnt_up == $past(cnt_up) + 16'h0001)
        else $error("upper word missed carry");
    casc_hold_a : assert property (@(posedge hclk) disable iff (!hresetn)
        cascade && !(tick_lo && (cnt_lo == 16'hFFFF || match32)) && !wr_pend
        |=> $stable(cnt_up))
        else $error("upper word moved without carry");
    match_flag_a : assert property (@(posedge hclk) disable iff (!hresetn)
        cascade && tick_lo && match32 |=> flag_up && cnt_lo == 16'h0000 && cnt_up == 16'h0000)
        else $error("32-bit match not handled");
    casc_noflag_a : assert property (@(posedge hclk) disable iff (!hresetn)
        cascade && !flag_lo && !wr_pend |=> !flag_lo)
        else $error("lower flag set in cascade");
    trig_src_a : assert property (@(posedge hclk) disable iff (!hresetn)
        adc_trigger |-> flag_up)
        else $error("trigger without upper match");
    run_stop_a : assert property (@(posedge hclk) disable iff (!hresetn)
        !run_lo && !wr_pend |=> $stable(cnt_lo))
        else $error("lower count moved while stopped");
    wrap16_a : assert property (@(posedge hclk) disable iff (!hresetn)
        !cascade && tick_lo && match_lo |=> cnt_lo == 16'h0000 && flag_lo)
        else $error("16-bit wrap wrong");
    prescale_a : assert property (@(posedge hclk) disable iff (!hresetn)
        run_lo && raw_lo && !tick_lo |=> ps_lo == $past(ps_lo) + 8'h01)
        else $error("prescaler did not advance");
    cnt_read_a : assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr == CTP_UP_CNT_OFS |=> hrdata == {16'h0000, $past(cnt_up)})
        else $error("count read wrong");
endmodule : ctp_timer_pair

//--- ctp_pin_model.sv
// pin-side model: external count clock, gate level and trigger tally
`timescale 1ns/100ps
module ctp_pin_model
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // bench controls
    input  wire logic        clk_en,
    input  wire logic        gate_en,
    // pins toward the timer pair
    output logic             ext_clk,
    output logic             gate,
    input  wire logic        adc_trigger,
    // tallies for the bench
    output logic [31:0]      n_edges,
    output logic [31:0]      n_trig
);
    logic [1:0] div;

    // slow count clock; stands low between bursts so no stray edge counts
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div <= 2'h0;
            ext_clk <= 1'b0;
            n_edges <= 32'h0;
        end
        else
        begin
            div <= div + 2'h1;
            if (!clk_en)
                ext_clk <= 1'b0;
            else if (div == 2'h3)
            begin
                ext_clk <= ~ext_clk;
                n_edges <= n_edges + {31'h0, ~ext_clk};
            end
        end
    end

    // gate level follows the bench; converter pulses are tallied
    assign gate = gate_en;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            n_trig <= 32'h0;
        else
            n_trig <= n_trig + {31'h0, adc_trigger};
    end
endmodule : ctp_pin_model

//--- test_cascadable_timer_pair.sv
// self-checking bench for the cascadable timer pair
`timescale 1ns/100ps
module test_cascadable_timer_pair;
    import ctp_pkg::*;
    localparam logic [31:0] RUN = 32'h1 << CTP_RUN_BIT;
    localparam logic [31:0] CAS = 32'h1 << CTP_CASC_BIT;
    localparam logic [31:0] EXT = 32'h1 << CTP_CSRC_BIT;
    localparam logic [31:0] GT  = 32'h1 << CTP_GATE_BIT;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        clk_en = 1'b0;
    logic        gate_en = 1'b0;
    wire logic [31:0] hrdata, n_edges, n_trig;
    wire logic   hreadyout, hresp, irq_lo, irq_up, adc_trigger, ext_clk, gate;
    logic [31:0] q, t0;
    int          n_fail = 0, n_compared = 0, cyc = 0, p, k;
    logic [7:0]  ofs [8] = '{CTP_LO_CTRL_OFS, CTP_UP_CTRL_OFS, CTP_LO_PER_OFS,
        CTP_UP_PER_OFS, CTP_LO_CNT_OFS, CTP_UP_CNT_OFS, CTP_FLAG_OFS, 8'h1C};
    logic [31:0] rst [8] = '{32'(CTP_CTRL_RST), 32'(CTP_CTRL_RST), 32'(CTP_PER_RST),
        32'(CTP_PER_RST), 32'(CTP_CNT_RST), 32'(CTP_CNT_RST), 32'h0, 32'h0};

    ctp_timer_pair ctp_timer_pair_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_clk_lo(ext_clk), .ext_clk_up(ext_clk), .gate_lo(gate), .gate_up(gate),
        .irq_lo(irq_lo), .irq_up(irq_up), .adc_trigger(adc_trigger));
    ctp_pin_model ctp_pin_model_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .gate_en(gate_en), .ext_clk(ext_clk), .gate(gate), .adc_trigger(adc_trigger),
        .n_edges(n_edges), .n_trig(n_trig));

    // 40 MHz clock
    always #12.5 hclk = ~hclk;

    // watchdog; a hang counts as a mismatch
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            results();
        end
    end

    task results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one single transfer; entered just after a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= CTP_HT_NSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= CTP_HT_IDLE;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // prescale divisor from the two-bit ratio field
    function automatic int div_of(input int s);
        return (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 64 : 256;
    endfunction : div_of

    // main sequence
    initial
    begin
        void'($urandom(32'h633C00F9));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 8; i++)
        begin
            rd(ofs[i]);
            chk("reset value", rst[i], q);
        end
        wr(8'h1C, 32'hFFFFFFFF);
        rd(8'h1C);
        chk("unmapped", 32'h0, q);
        chk("okay response", 32'h0, 32'(hresp));
        wr(CTP_LO_PER_OFS, 32'h10);
        repeat (20) @(posedge hclk);
        rd(CTP_LO_CNT_OFS);
        chk("idle count", 32'h0, q);
        repeat (3)
        begin
            p = $urandom_range(40, 4);
            t0 = n_trig;
            wr(CTP_LO_CNT_OFS, 32'h0);
            wr(CTP_LO_PER_OFS, 32'(p));
            wr(CTP_FLAG_OFS, 32'h3);
            wr(CTP_LO_CTRL_OFS, RUN);
            for (k = 0; k < 200 && irq_lo !== 1'b1; k++) @(posedge hclk);
            chk("lo match delay", 32'h1, 32'(k >= p && k <= p + 4));
            wr(CTP_LO_CTRL_OFS, 32'h0);
            rd(CTP_LO_CNT_OFS);
            chk("lo count bound", 32'h1, 32'(q <= p));
            chk("lo no trigger", t0, n_trig);
            chk("up flag quiet", 32'h0, 32'(irq_up));
            wr(CTP_FLAG_OFS, 32'h1);
            rd(CTP_FLAG_OFS);
            chk("flag clear", 32'h0, q);
        end
        t0 = n_trig;
        wr(CTP_UP_PER_OFS, 32'h6);
        wr(CTP_UP_CTRL_OFS, RUN);
        repeat (30) @(posedge hclk);
        wr(CTP_UP_CTRL_OFS, 32'h0);
        chk("up trigger", 32'h1, 32'(n_trig - t0 >= 3 && n_trig - t0 <= 5));
        chk("up flag", 32'h1, 32'(irq_up));
        wr(CTP_LO_PER_OFS, 32'hFFFF);
        for (int s = 0; s < 4; s++)
        begin
            wr(CTP_LO_CNT_OFS, 32'h0);
            wr(CTP_LO_CTRL_OFS, RUN | (32'(s) << CTP_PS_LO));
            repeat (1024) @(posedge hclk);
            wr(CTP_LO_CTRL_OFS, 32'h0);
            rd(CTP_LO_CNT_OFS);
            p = 1024 / div_of(s);
            chk("prescale", 32'h1, 32'(q + 1 >= p && q <= p + 2));
        end
        wr(CTP_LO_CNT_OFS, 32'h0);
        wr(CTP_LO_CTRL_OFS, RUN | EXT);
        t0 = n_edges;
        clk_en <= 1'b1;
        repeat (8 * $urandom_range(30, 5)) @(posedge hclk);
        clk_en <= 1'b0;
        repeat (10) @(posedge hclk);
        rd(CTP_LO_CNT_OFS);
        chk("ext edges", n_edges - t0, q);
        wr(CTP_LO_CNT_OFS, 32'h0);
        wr(CTP_LO_CTRL_OFS, RUN | GT);
        gate_en <= 1'b1;
        repeat (40) @(posedge hclk);
        gate_en <= 1'b0;
        repeat (10) @(posedge hclk);
        rd(CTP_LO_CNT_OFS);
        chk("gated", 32'h1, 32'(q >= 36 && q <= 41));
        wr(CTP_UP_PER_OFS, 32'hFFFF);
        wr(CTP_LO_CNT_OFS, 32'hFFFE);
        wr(CTP_UP_CNT_OFS, 32'h5);
        wr(CTP_UP_CTRL_OFS, RUN | 32'h30);
        wr(CTP_LO_CTRL_OFS, RUN | CAS);
        repeat (4) @(posedge hclk);
        wr(CTP_LO_CTRL_OFS, CAS);
        rd(CTP_UP_CNT_OFS);
        chk("carry word", 32'h6, q);
        rd(CTP_LO_CNT_OFS);
        chk("low word", 32'h1, 32'(q < 16));
        wr(CTP_FLAG_OFS, 32'h3);
        t0 = n_trig;
        wr(CTP_LO_CNT_OFS, 32'hFFFD);
        wr(CTP_UP_CNT_OFS, 32'h0);
        wr(CTP_LO_PER_OFS, 32'h2);
        wr(CTP_UP_PER_OFS, 32'h1);
        wr(CTP_LO_CTRL_OFS, RUN | CAS);
        for (k = 0; k < 50 && irq_up !== 1'b1; k++) @(posedge hclk);
        wr(CTP_LO_CTRL_OFS, CAS);
        chk("wide match", 32'h1, 32'(k >= 4 && k <= 10));
        rd(CTP_FLAG_OFS);
        chk("wide flag", 32'h2, q);
        chk("wide trigger", 32'h1, 32'(n_trig != t0));
        results();
    end
endmodule : test_cascadable_timer_pair
